// *** hw/disk_cmd_consts.svh ***
/*
 Constants for the disk command decoder: task-file offsets, field
 positions, opcodes, controller register offsets and status bits.
 Assumes inclusion by bare name from the design and testbench files.
*/
`ifndef DISK_CMD_CONSTS_SVH
`define DISK_CMD_CONSTS_SVH

// ---------------------------------------------------------------
// Task-file offsets
// ---------------------------------------------------------------
`define TF_FEATURE 10'h1f1
`define TF_SECCNT 10'h1f2
`define TF_SECNUM 10'h1f3
`define TF_CYL_LO 10'h1f4
`define TF_CYL_HI 10'h1f5
`define TF_DRVHD 10'h1f6
`define TF_OPCODE 10'h1f7

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DH_LBA_BIT 6
`define DH_DEV_BIT 4
`define ST_BUSY_BIT 7
`define ST_DRDY_BIT 6
`define ST_DSC_BIT 4
`define ST_DRQ_BIT 3
`define ST_ERR_BIT 0
`define ER_ABRT_BIT 2

// ---------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------
`define OP_RD_SEC 8'h20
`define OP_RD_LONG 8'h22
`define OP_RD_VER 8'h40
`define OP_RD_MULT 8'hc4
`define OP_RD_DMA 8'hc8
`define OP_WR_SEC 8'h30
`define OP_WR_LONG 8'h32
`define OP_WR_VER 8'h3c
`define OP_WR_MULT 8'hc5
`define OP_WR_DMA 8'hca
`define OP_RECAL_HI 4'h1
`define OP_SEEK_HI 4'h7
`define OP_FORMAT 8'h50
`define OP_DIAG 8'h90
`define OP_INIT 8'h91
`define OP_SET_MULT 8'hc6
`define OP_RD_BUF 8'he4
`define OP_WR_BUF 8'he8
`define OP_IDENT 8'hec
`define OP_IDENT_DMA 8'hee
`define OP_SET_FEAT 8'hef
`define OP_IDLE_A 8'h97
`define OP_IDLE_B 8'he3
`define OP_IDLEI_A 8'h95
`define OP_IDLEI_B 8'he1
`define OP_STBY_A 8'h96
`define OP_STBY_B 8'he2
`define OP_STBYI_A 8'h94
`define OP_STBYI_B 8'he0
`define OP_SLEEP_A 8'h99
`define OP_SLEEP_B 8'he6
`define OP_CHKPWR_A 8'h98
`define OP_CHKPWR_B 8'he5
`define OP_SMART 8'hb0
`define OP_FLUSH 8'he7
`define OP_SEC_SETPW 8'hf1
`define OP_SEC_UNLOCK 8'hf2
`define OP_SEC_ERPREP 8'hf3
`define OP_SEC_ERUNIT 8'hf4
`define OP_SEC_FREEZE 8'hf5
`define OP_SEC_DISPW 8'hf6
`define OP_RD_NMAX 8'hf8
`define OP_SET_MAX 8'hf9

// ---------------------------------------------------------------
// Controller APB registers
// ---------------------------------------------------------------
`define CR_FEATURE 12'h000
`define CR_SECCNT 12'h004
`define CR_SECNUM 12'h008
`define CR_CYL 12'h00c
`define CR_DRVHD 12'h010
`define CR_ISSUE 12'h014
`define CR_RESULT 12'h018
`define CR_LBA 12'h01c
`define CR_IRQ_STAT 12'h020
`define CR_IRQ_MASK 12'h024
`define CR_LOAD_MASK 12'h028
`define CR_TF_DATA 12'h02c
`define IRQ_DONE_BIT 0
`define IRQ_ERR_BIT 1
`define IRQ_REFUSED_BIT 2
`define IRQ_WIDTH 3
`define DEV_SECTOR_CYCLES 8'h04
`define MISMATCH_OPCODE 8'h00

`endif

// *** hw/disk_cmd_pkg.sv ***
/*
 Types shared by both ends of the disk command decoder.
 Assumes the constants header is on the include path.
*/
package disk_cmd_pkg;
    typedef enum logic [2:0] {
        CLS_NONE, CLS_READ, CLS_WRITE, CLS_NODATA, CLS_DIAG, CLS_BAD
    } cmd_class_t;

    // Parameter registers a command consumes: fr, sc, sn, cy, dh(head bits)
    typedef struct packed {
        logic fr;
        logic sc;
        logic sn;
        logic cy;
        logic dh_head;
    } use_mask_t;

    typedef enum logic [1:0] {
        DEV_IDLE, DEV_EXEC, DEV_DONE
    } dev_state_t;

    typedef enum logic [2:0] {
        HST_IDLE, HST_WAIT_BUSY, HST_LOAD, HST_OPCODE, HST_POLL
    } host_state_t;
endpackage

// *** hw/disk_tf_if.sv ***
/*
 Task-file link between host controller and drive.
 Assumes one clock; writes are single-cycle strobes, reads are held while polling.
*/
`timescale 1ns/100ps
`default_nettype none
interface disk_tf_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic [9:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic busy;
    logic data_request_flag;

    modport dev (input addr, wr, rd, wdata, output rdata, busy, data_request_flag);
    modport host (output addr, wr, rd, wdata, input rdata, busy, data_request_flag);
endinterface
`default_nettype wire

// *** hw/disk_cmd_device.sv ***
/*
 Drive end: task-file registers, opcode decode, parameter use,
 address formation and completion or error register contents.
 Assumes the host writes parameters first and only while not busy.
*/
// The APB interface to the registers is this design's own decision.
// Overview of operation
// - Read opcodes decode, retry bit ignored
// - Write opcodes decode as listed
// - Misc opcodes decode, recalibrate/seek nibble ignored
// - Each power command accepts two opcodes
// - SMART, flush, security, max opcodes decode
// - Host loads address registers before data commands
// - Format uses sector number only in LBA
// - Unused parameter registers are ignored
// - Device-only commands ignore head bits
// - Diagnostic runs on master and slave
// - LBA mode forms 28-bit block address
// - Error leaves remaining sector count
// - Success reports last sector, count zero
// - Host writes needed parameters before opcode
// - Opcode accepted only while not busy
// - Execution starts right after opcode write
// - Drive bit selects master or slave
`timescale 1ns/100ps
`default_nettype none
`include "disk_cmd_consts.svh"
module disk_cmd_device #(
    parameter logic IS_SLAVE = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    disk_tf_if.dev tf,
    input wire logic media_fault,
    output logic [27:0] block_addr,
    output logic [4:0] used_regs,
    output logic [2:0] cmd_class,
    output logic head_honoured
);
    typedef struct packed {
        disk_cmd_pkg::dev_state_t st;
        logic [7:0] feature;
        logic [7:0] seccnt;
        logic [7:0] secnum;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] drvhd;
        logic [7:0] opcode;
        logic [7:0] err;
        logic err_flag;
        logic [7:0] timer;
        disk_cmd_pkg::cmd_class_t cls;
        disk_cmd_pkg::use_mask_t use_m;
        logic [27:0] addr;
    } dev_t;

    dev_t state_reg;
    dev_t state_next;
    disk_cmd_pkg::cmd_class_t dec_cls;
    disk_cmd_pkg::use_mask_t dec_use;
    logic selected;
    logic lba_mode;
    logic [7:0] status;

    // ---------------------------------------------------------------
    // Opcode decode
    // ---------------------------------------------------------------
    always_comb begin
        dec_cls = disk_cmd_pkg::CLS_BAD;
        dec_use = '{fr: 1'b0, sc: 1'b0, sn: 1'b0, cy: 1'b0, dh_head: 1'b0};
        if (tf.wdata[7:1] == `OP_RD_SEC >> 1 ||
            tf.wdata[7:1] == `OP_RD_LONG >> 1 ||
            tf.wdata[7:1] == `OP_RD_VER >> 1 ||
            tf.wdata == `OP_RD_MULT ||
            tf.wdata[7:1] == `OP_RD_DMA >> 1) begin
            dec_cls = disk_cmd_pkg::CLS_READ;
            dec_use = '{fr: 1'b0, sc: 1'b1, sn: 1'b1, cy: 1'b1, dh_head: 1'b1};
        end else if (tf.wdata[7:1] == `OP_WR_SEC >> 1 ||
            tf.wdata[7:1] == `OP_WR_LONG >> 1 ||
            tf.wdata == `OP_WR_VER || tf.wdata == `OP_WR_MULT ||
            tf.wdata[7:1] == `OP_WR_DMA >> 1) begin
            dec_cls = disk_cmd_pkg::CLS_WRITE;
            dec_use = '{fr: 1'b0, sc: 1'b1, sn: 1'b1, cy: 1'b1, dh_head: 1'b1};
        end else if (tf.wdata == `OP_SET_MAX) begin
            dec_cls = disk_cmd_pkg::CLS_NODATA;
            dec_use = '{fr: 1'b0, sc: 1'b1, sn: 1'b1, cy: 1'b1, dh_head: 1'b1};
        end else if (tf.wdata[7:4] == `OP_SEEK_HI) begin
            dec_cls = disk_cmd_pkg::CLS_NODATA;
            dec_use = '{fr: 1'b0, sc: 1'b0, sn: 1'b1, cy: 1'b1, dh_head: 1'b1};
        end else if (tf.wdata == `OP_FORMAT) begin
            dec_cls = disk_cmd_pkg::CLS_WRITE;
            dec_use = '{fr: 1'b0, sc: 1'b0, sn: lba_mode, cy: 1'b1,
                dh_head: 1'b1};
        end else if (tf.wdata == `OP_DIAG) begin
            dec_cls = disk_cmd_pkg::CLS_DIAG;
        end else if (tf.wdata == `OP_INIT) begin
            dec_cls = disk_cmd_pkg::CLS_NODATA;
            dec_use = '{fr: 1'b0, sc: 1'b1, sn: 1'b0, cy: 1'b0, dh_head: 1'b1};
        end else if (tf.wdata == `OP_SMART) begin
            dec_cls = disk_cmd_pkg::CLS_NODATA;
            dec_use = '{fr: 1'b1, sc: 1'b1, sn: 1'b1, cy: 1'b1, dh_head: 1'b0};
        end else if (tf.wdata == `OP_SET_FEAT) begin
            dec_cls = disk_cmd_pkg::CLS_NODATA;
            dec_use = '{fr: 1'b1, sc: 1'b1, sn: 1'b0, cy: 1'b0, dh_head: 1'b0};
        end else if (tf.wdata == `OP_SET_MULT || tf.wdata == `OP_IDLE_A ||
            tf.wdata == `OP_IDLE_B || tf.wdata == `OP_STBY_A ||
            tf.wdata == `OP_STBY_B) begin
            dec_cls = disk_cmd_pkg::CLS_NODATA;
            dec_use = '{fr: 1'b0, sc: 1'b1, sn: 1'b0, cy: 1'b0, dh_head: 1'b0};
        end else if (tf.wdata[7:4] == `OP_RECAL_HI ||
            tf.wdata == `OP_IDLEI_A || tf.wdata == `OP_IDLEI_B ||
            tf.wdata == `OP_STBYI_A || tf.wdata == `OP_STBYI_B ||
            tf.wdata == `OP_SLEEP_A || tf.wdata == `OP_SLEEP_B ||
            tf.wdata == `OP_CHKPWR_A || tf.wdata == `OP_CHKPWR_B ||
            tf.wdata == `OP_FLUSH || tf.wdata == `OP_RD_NMAX ||
            (tf.wdata >= `OP_SEC_SETPW && tf.wdata <= `OP_SEC_DISPW))
        begin
            dec_cls = disk_cmd_pkg::CLS_NODATA;
        end else if (tf.wdata == `OP_RD_BUF || tf.wdata == `OP_IDENT ||
            tf.wdata == `OP_IDENT_DMA) begin
            dec_cls = disk_cmd_pkg::CLS_READ;
        end else if (tf.wdata == `OP_WR_BUF) begin
            dec_cls = disk_cmd_pkg::CLS_WRITE;
        end
    end

    // ---------------------------------------------------------------
    // Selection, address and status
    // ---------------------------------------------------------------
    assign selected = state_reg.drvhd[`DH_DEV_BIT] == IS_SLAVE;
    assign lba_mode = state_reg.drvhd[`DH_LBA_BIT];
    assign status = {state_reg.st == disk_cmd_pkg::DEV_EXEC, 1'b1, 1'b0,
        1'b1, 1'b0, 2'b00, state_reg.err_flag};
    assign tf.busy = selected && state_reg.st == disk_cmd_pkg::DEV_EXEC;
    assign tf.data_request_flag = 1'b0;

    always_comb begin
        tf.rdata = 8'h00;
        if (!selected) begin
            tf.rdata = 8'h00;
        end else if (state_reg.st == disk_cmd_pkg::DEV_EXEC) begin
            tf.rdata = status;
        end else if (tf.addr == `TF_FEATURE) begin
            tf.rdata = state_reg.err;
        end else if (tf.addr == `TF_SECCNT) begin
            tf.rdata = state_reg.seccnt;
        end else if (tf.addr == `TF_SECNUM) begin
            tf.rdata = state_reg.secnum;
        end else if (tf.addr == `TF_CYL_LO) begin
            tf.rdata = state_reg.cyl_lo;
        end else if (tf.addr == `TF_CYL_HI) begin
            tf.rdata = state_reg.cyl_hi;
        end else if (tf.addr == `TF_DRVHD) begin
            tf.rdata = state_reg.drvhd;
        end else if (tf.addr == `TF_OPCODE) begin
            tf.rdata = status;
        end
    end

    // ---------------------------------------------------------------
    // Register file and execution
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        if (state_reg.st == disk_cmd_pkg::DEV_DONE) begin
            state_next.st = disk_cmd_pkg::DEV_IDLE;
        end
        if (tf.wr && state_reg.st != disk_cmd_pkg::DEV_EXEC) begin
            if (tf.addr == `TF_FEATURE) begin
                state_next.feature = tf.wdata;
            end else if (tf.addr == `TF_SECCNT) begin
                state_next.seccnt = tf.wdata;
            end else if (tf.addr == `TF_SECNUM) begin
                state_next.secnum = tf.wdata;
            end else if (tf.addr == `TF_CYL_LO) begin
                state_next.cyl_lo = tf.wdata;
            end else if (tf.addr == `TF_CYL_HI) begin
                state_next.cyl_hi = tf.wdata;
            end else if (tf.addr == `TF_DRVHD) begin
                state_next.drvhd = tf.wdata;
            end else if (tf.addr == `TF_OPCODE &&
                (selected || tf.wdata == `OP_DIAG)) begin
                state_next.opcode = tf.wdata;
                state_next.cls = dec_cls;
                state_next.use_m = dec_use;
                state_next.err = 8'h00;
                state_next.err_flag = 1'b0;
                state_next.timer = `DEV_SECTOR_CYCLES;
                state_next.st = disk_cmd_pkg::DEV_EXEC;
                // Unused fields are masked to zero in the address
                state_next.addr = lba_mode ? {state_reg.drvhd[3:0] &
                    {4{dec_use.dh_head}}, state_reg.cyl_hi &
                    {8{dec_use.cy}}, state_reg.cyl_lo & {8{dec_use.cy}},
                    state_reg.secnum & {8{dec_use.sn}}} :
                    {state_reg.drvhd[3:0] & {4{dec_use.dh_head}}, 8'h00,
                    8'h00, state_reg.secnum & {8{dec_use.sn}}};
                if (dec_cls == disk_cmd_pkg::CLS_BAD) begin
                    state_next.err[`ER_ABRT_BIT] = 1'b1;
                    state_next.err_flag = 1'b1;
                    state_next.st = disk_cmd_pkg::DEV_DONE;
                end
            end
        end
        if (state_reg.st == disk_cmd_pkg::DEV_EXEC) begin
            state_next.timer = state_reg.timer - 8'h01;
            if (media_fault && (state_reg.cls == disk_cmd_pkg::CLS_READ ||
                state_reg.cls == disk_cmd_pkg::CLS_WRITE)) begin
                state_next.err_flag = 1'b1;
                state_next.st = disk_cmd_pkg::DEV_DONE;
            end else if (state_reg.timer == 8'h00) begin
                if (state_reg.use_m.sc && state_reg.seccnt != 8'h01 &&
                    state_reg.cls != disk_cmd_pkg::CLS_NODATA) begin
                    state_next.seccnt = state_reg.seccnt - 8'h01;
                    state_next.secnum = state_reg.secnum + 8'h01;
                    state_next.timer = `DEV_SECTOR_CYCLES;
                end else begin
                    if (state_reg.use_m.sc &&
                        state_reg.cls != disk_cmd_pkg::CLS_NODATA) begin
                        state_next.seccnt = 8'h00;
                    end
                    state_next.st = disk_cmd_pkg::DEV_DONE;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign block_addr = state_reg.addr;
    assign used_regs = state_reg.use_m;
    assign cmd_class = state_reg.cls;
    assign head_honoured = state_reg.use_m.dh_head;
endmodule
`default_nettype wire

// *** hw/disk_cmd_host.sv ***
/*
 Host end: APB slave with parameter and issue registers; writes the
 task file in order and polls for completion. Assumes one drive end.
*/
`timescale 1ns/100ps
`default_nettype none
`include "disk_cmd_consts.svh"
module disk_cmd_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    disk_tf_if.host tf
);
    typedef struct packed {
        disk_cmd_pkg::host_state_t st;
        logic [7:0] feature;
        logic [7:0] seccnt;
        logic [7:0] secnum;
        logic [15:0] cyl;
        logic [7:0] drvhd;
        logic [7:0] opcode;
        logic [4:0] load_mask;
        logic [2:0] step;
        logic [7:0] result;
        logic [`IRQ_WIDTH-1:0] irq_stat;
        logic [`IRQ_WIDTH-1:0] irq_mask;
        logic [9:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
        logic [7:0] tf_data;
        logic [31:0] rdata;
    } host_t;

    host_t state_reg;
    host_t state_next;
    logic acc;
    logic [9:0] load_addr;
    logic [7:0] load_data;
    logic load_want;

    assign acc = psel && penable;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = state_reg.rdata;
    assign irq = |(state_reg.irq_stat & state_reg.irq_mask);
    assign tf.addr = state_reg.addr;
    assign tf.wr = state_reg.wr;
    assign tf.rd = state_reg.rd;
    assign tf.wdata = state_reg.wdata;

    // ---------------------------------------------------------------
    // Parameter load sequence
    // ---------------------------------------------------------------
    always_comb begin
        load_addr = `TF_FEATURE;
        load_data = state_reg.feature;
        load_want = state_reg.load_mask[4];
        case (state_reg.step)
            3'd1: begin
                load_addr = `TF_SECCNT;
                load_data = state_reg.seccnt;
                load_want = state_reg.load_mask[3];
            end
            3'd2: begin
                load_addr = `TF_SECNUM;
                load_data = state_reg.secnum;
                load_want = state_reg.load_mask[2];
            end
            3'd3: begin
                load_addr = `TF_CYL_LO;
                load_data = state_reg.cyl[7:0];
                load_want = state_reg.load_mask[1];
            end
            3'd4: begin
                load_addr = `TF_CYL_HI;
                load_data = state_reg.cyl[15:8];
                load_want = state_reg.load_mask[1];
            end
            3'd5: begin
                load_addr = `TF_DRVHD;
                load_data = state_reg.drvhd;
                load_want = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // ---------------------------------------------------------------
    // APB registers and sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.wr = 1'b0;
        state_next.rd = 1'b0;
        if (acc && !pwrite && paddr == `CR_IRQ_STAT) begin
            state_next.irq_stat = state_reg.irq_stat &
                ~state_reg.rdata[`IRQ_WIDTH-1:0];
        end
        if (psel && !penable && !pwrite) begin
            state_next.rdata = 32'h0000_0000;
            if (paddr == `CR_RESULT) begin
                state_next.rdata = {23'h00_0000,
                    state_reg.st != disk_cmd_pkg::HST_IDLE, state_reg.result};
            end else if (paddr == `CR_IRQ_STAT) begin
                state_next.rdata = {29'h0000_0000, state_reg.irq_stat};
            end else if (paddr == `CR_IRQ_MASK) begin
                state_next.rdata = {29'h0000_0000, state_reg.irq_mask};
            end else if (paddr == `CR_TF_DATA) begin
                state_next.rdata = {24'h00_0000, state_reg.tf_data};
            end else if (paddr == `CR_LBA) begin
                state_next.rdata = {24'h00_0000, state_reg.drvhd};
            end
        end
        if (acc && pwrite) begin
            if (paddr == `CR_FEATURE) begin
                state_next.feature = pwdata[7:0];
            end else if (paddr == `CR_SECCNT) begin
                state_next.seccnt = pwdata[7:0];
            end else if (paddr == `CR_SECNUM) begin
                state_next.secnum = pwdata[7:0];
            end else if (paddr == `CR_CYL) begin
                state_next.cyl = pwdata[15:0];
            end else if (paddr == `CR_DRVHD) begin
                state_next.drvhd = pwdata[7:0];
            end else if (paddr == `CR_IRQ_MASK) begin
                state_next.irq_mask = pwdata[`IRQ_WIDTH-1:0];
            end else if (paddr == `CR_LOAD_MASK) begin
                state_next.load_mask = pwdata[4:0];
            end else if (paddr == `CR_ISSUE) begin
                if (state_reg.st == disk_cmd_pkg::HST_IDLE) begin
                    state_next.opcode = pwdata[7:0];
                    state_next.st = disk_cmd_pkg::HST_WAIT_BUSY;
                end else begin
                    state_next.irq_stat[`IRQ_REFUSED_BIT] = 1'b1;
                end
            end
        end
        case (state_reg.st)
            disk_cmd_pkg::HST_WAIT_BUSY: begin
                if (!tf.busy && !tf.data_request_flag) begin
                    state_next.step = 3'd0;
                    state_next.st = disk_cmd_pkg::HST_LOAD;
                end
            end
            disk_cmd_pkg::HST_LOAD: begin
                state_next.addr = load_addr;
                state_next.wdata = load_data;
                state_next.wr = load_want;
                state_next.step = state_reg.step + 3'd1;
                if (state_reg.step == 3'd5) begin
                    state_next.st = disk_cmd_pkg::HST_OPCODE;
                end
            end
            disk_cmd_pkg::HST_OPCODE: begin
                state_next.addr = `TF_OPCODE;
                state_next.wdata = state_reg.opcode;
                state_next.wr = 1'b1;
                state_next.st = disk_cmd_pkg::HST_POLL;
            end
            disk_cmd_pkg::HST_POLL: begin
                state_next.addr = `TF_OPCODE;
                state_next.rd = 1'b1;
                if (state_reg.rd && !tf.rdata[`ST_BUSY_BIT]) begin
                    state_next.result = tf.rdata;
                    state_next.rd = 1'b0;
                    state_next.st = disk_cmd_pkg::HST_IDLE;
                    state_next.irq_stat[`IRQ_DONE_BIT] = 1'b1;
                    if (tf.rdata[`ST_ERR_BIT]) begin
                        state_next.irq_stat[`IRQ_ERR_BIT] = 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule
`default_nettype wire

// *** tb/disk_cmd_monitor.sv ***
/* Checker on the task-file link between host and drive ends.
 Assumes the testbench wires it beside the link interface. */
`timescale 1ns/100ps
`default_nettype none
module disk_cmd_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [9:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic busy,
    input wire logic data_request_flag
);
    logic slv;
    logic op_wr;
    logic [10:0] bcnt;
    assign op_wr = wr && addr == 10'h1f7;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) {slv, bcnt} <= '0;
        else begin
            if (wr && addr == 10'h1f6) slv <= wdata[4];
            bcnt <= busy ? bcnt + 11'd1 : 11'd0;
        end
    end
    property p_go; op_wr && !busy && !slv && wdata[7:1] == 7'h10 |=> busy;
    endproperty
    a_go: assert property (p_go) else $error("read not started");
    property p_bad; op_wr && !busy && wdata == 8'h00 |=> !busy; endproperty
    a_bad: assert property (p_bad) else $error("bad opcode ran");
    property p_sel; op_wr && slv && wdata != 8'h90 |=> !busy; endproperty
    a_sel: assert property (p_sel) else $error("other drive ran");
    property p_nowr; op_wr |-> !busy; endproperty
    a_nowr: assert property (p_nowr) else $error("write while busy");
    property p_ord; op_wr |-> $past(wr) && $past(addr) == 10'h1f6; endproperty
    a_ord: assert property (p_ord) else $error("opcode order");
    property p_drq; !data_request_flag; endproperty
    a_drq: assert property (p_drq) else $error("data request set");
    property p_st; rd && busy |-> rdata[7]; endproperty
    a_st: assert property (p_st) else $error("status not busy");
    property p_end; busy |-> bcnt < 11'd1280; endproperty
    a_end: assert property (p_end) else $error("command hangs");
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/* Testbench joining host and master drive over the task-file link.
 Assumes the consts header on the include path. */
`timescale 1ns/100ps
`default_nettype none
`include "disk_cmd_consts.svh"
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, media_fault, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [31:0] sd = 32'h0000_0050;
    logic [27:0] block_addr;
    logic [4:0] used_regs;
    logic [2:0] cmd_class;
    logic head_honoured;
    logic [7:0] sc, sn, dh;
    logic [15:0] cy;
    logic [31:0] q[$];
    int error_cnt = 0;
    int total_checks = 0;
    logic [7:0] op[7] = '{8'h21, 8'h3c, 8'h7a, 8'he3, 8'h90, 8'h00, 8'h20};
    logic [2:0] cl[7] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h0};
    logic [4:0] ur[7] = '{5'h0f, 5'h0f, 5'h07, 5'h08, 5'h00, 5'h00, 5'h00};
    always #20 pclk = ~pclk;
    disk_tf_if i_disk_tf_if (.pclk(pclk), .presetn(presetn));
    disk_cmd_host i_disk_cmd_host (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
        .tf(i_disk_tf_if.host));
    disk_cmd_device i_disk_cmd_device (.pclk, .presetn, .media_fault,
        .tf(i_disk_tf_if.dev), .block_addr, .used_regs, .cmd_class,
        .head_honoured);
    disk_cmd_monitor i_disk_cmd_monitor (.pclk, .presetn,
        .addr(i_disk_tf_if.addr), .wr(i_disk_tf_if.wr), .rd(i_disk_tf_if.rd),
        .wdata(i_disk_tf_if.wdata), .rdata(i_disk_tf_if.rdata),
        .busy(i_disk_tf_if.busy), .data_request_flag(i_disk_tf_if.data_request_flag));
    function automatic logic [31:0] xs();
        sd ^= sd << 13;
        sd ^= sd >> 17;
        sd ^= sd << 5;
        return sd;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Read data doubles as the expected value
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) q.push_back(d);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            finish_test();
        end
        @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite)
            chk(prdata, q.pop_front());
    end
    initial begin
        int n;
        {psel, penable, pwrite, paddr, pwdata, media_fault} <= '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `CR_IRQ_MASK, 32'h0000_0000);
        apb(1'b0, `CR_TF_DATA, 32'h0000_0000);
        apb(1'b1, `CR_IRQ_MASK, 32'h0000_0007);
        apb(1'b1, `CR_LOAD_MASK, 32'h0000_001e);
        for (int i = 0; i < 7; i++) begin
            sc = 8'(xs() % 7 + 1);
            sn = 8'(xs());
            cy = 16'(xs());
            dh = {3'h7, i == 6, 4'(xs())};
            er = i == 1 || i == 5;
            media_fault <= i == 1;
            apb(1'b1, `CR_FEATURE, xs());
            apb(1'b1, `CR_SECCNT, 32'(sc));
            apb(1'b1, `CR_SECNUM, 32'(sn));
            apb(1'b1, `CR_CYL, 32'(cy));
            apb(1'b1, `CR_DRVHD, 32'(dh));
            apb(1'b1, `CR_ISSUE, 32'(op[i]));
            if (i == 0) begin
                apb(1'b1, `CR_ISSUE, 32'h0000_0021);
                apb(1'b0, `CR_IRQ_STAT, 32'h0000_0004);
            end
            n = 0;
            while (irq !== 1'b1 && n < 3000) begin
                @(posedge pclk);
                n++;
            end
            if (n >= 3000) begin
                error_cnt++;
                finish_test();
            end
            apb(1'b0, `CR_IRQ_STAT, {30'h0, er, 1'b1});
            apb(1'b0, `CR_RESULT, i == 6 ? 0 : {24'h0, 7'h28, er});
            @(negedge pclk);
            chk(32'(irq), 0);
            if (i < 6) chk(32'(cmd_class), 32'(cl[i]));
            if (i < 5) chk(32'(used_regs), 32'(ur[i]));
            if (i < 5) chk(32'(head_honoured), 32'(ur[i][0]));
            if (ur[i][1])
                chk(32'(block_addr), {4'h0, dh[3:0], cy, sn});
            @(posedge pclk);
        end
        media_fault <= 1'b0;
        apb(1'b1, `CR_IRQ_MASK, 32'h0000_0000);
        apb(1'b1, `CR_ISSUE, 32'h0000_00e7);
        repeat (60) @(posedge pclk);
        chk(32'(irq), 0);
        apb(1'b0, `CR_IRQ_STAT, 32'h0000_0001);
        finish_test();
    end
endmodule
`default_nettype wire
